/* core/bus_idle_timer.v */
// Bus idle timer that raises the host suspend indication.
// Assumes bus_active is a synchronous level from the device core.
`timescale 1ns/100ps
`include "usb_app_map.vh"

module bus_idle_timer #(
	parameter [`SUSPEND_CNT_W-1:0] IDLE_CYCLES = `SUSPEND_CYCLES
) (
	input  wire clk,           // Core clock.
	input  wire arst_n,        // Asynchronous reset, active low.
	input  wire bus_active,    // High while the bus carries traffic.
	output reg  suspended_r    // High after the idle time has passed.
);

	reg [`SUSPEND_CNT_W-1:0] idle_cnt_r;

	// Count idle cycles; any traffic restarts the count and drops suspend.
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			idle_cnt_r  <= {`SUSPEND_CNT_W{1'b0}};
			suspended_r <= 1'b0;
		end else if (bus_active) begin
			idle_cnt_r  <= {`SUSPEND_CNT_W{1'b0}};
			suspended_r <= 1'b0;
		end else if (idle_cnt_r >= IDLE_CYCLES - 1'b1) begin
			suspended_r <= 1'b1;
		end else begin
			idle_cnt_r <= idle_cnt_r + 1'b1;
		end
	end

endmodule

/* core/port_change_detect.v */
// Port seven change detector for the port-change interrupt.
// Assumes pins are synchronous and port_read pulses on each port seven read.
`timescale 1ns/100ps
`include "usb_app_map.vh"

module port_change_detect (
	input  wire       clk,         // Core clock.
	input  wire       arst_n,      // Asynchronous reset, active low.
	input  wire [3:0] pins,        // Port seven pins seven down to four.
	input  wire [3:0] dir_in,      // High where the pin is an input.
	input  wire       port_read,   // One-cycle pulse on a port seven read.
	input  wire [1:0] op_mode,     // Operation mode code.
	output reg        change_r     // One-cycle pulse when a mismatch begins.
);

	reg  [3:0] latched_r;
	reg        mismatch_r;
	reg  [3:0] watch;
	wire       mismatch;

	// Pick the pins that take part in the selected mode.
	always @* begin
		case (op_mode)
			`MODE_SERIAL: watch = dir_in;
			`MODE_USB:    watch = 4'hc & dir_in;
			default:      watch = 4'h0;
		endcase
	end

	assign mismatch = |((pins ^ latched_r) & watch);

	// Latch on each read and pulse on the rising edge of a mismatch.
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			latched_r  <= 4'h0;
			mismatch_r <= 1'b0;
			change_r   <= 1'b0;
		end else begin
			if (port_read) begin
				latched_r <= pins;
			end
			mismatch_r <= mismatch & ~port_read;
			change_r   <= mismatch & ~port_read & ~mismatch_r;
		end
	end

endmodule

/* core/usb_app_fifo_status_regs.v */
// Register bank between firmware and the on-chip USB device core.
// Holds endpoint status flags, interrupt flags, the FIFO pointer and the
// 32-byte application FIFO. Assumes all inputs are synchronous to clk and
// that firmware and core requests are single-cycle strobes.
`timescale 1ns/100ps
`include "usb_app_map.vh"

// Function
// - Firmware sets stall; a completed Setup transaction clears it.
// - Read-only busy flag shows the core accessing the endpoint-zero FIFO.
// - Suspend flag rises after 3.0 ms bus idle, drops on activity.
// - Endpoint-two receive flag set on arrival, blocks more data until cleared.
// - Firmware sets transmit requests; core clears them after sending.
// - Endpoint-zero receive flag set on core write; core writes only when clear.
// - Pointer holds five bits; upper three bits read as zero.
// - Data window accesses the FIFO byte the pointer selects.
// - Endpoint-zero FIFO starts at 0x00; its byte index sits at 0x10.
// - Timer overflow flag set by tick counter overflow.
// - Endpoint-zero flag set on vendor or custom command while the USB core runs.
// - Suspend interrupt flag set when suspend is seen.
// - Bus reset flag set when the host signals reset while the USB core runs.
// - Port-change flag from port seven inputs, pins chosen by mode.
// - Two pattern-detect flags, one per detector.
// - Resume flag set with dual clock control clear when suspend falls.
// - Accumulator saved by hardware when an interrupt is taken.
// - Two-bit mode field picks detect, USB, serial or test mode.
// - Clearing dual clock control stops the USB core.
module usb_app_fifo_status_regs #(
	parameter [`SUSPEND_CNT_W-1:0] SUSPEND_CYCLES = `SUSPEND_CYCLES
) (
	input  wire       clk,                // Core clock, 125 MHz.
	input  wire       arst_n,             // Asynchronous reset, active low.
	input  wire [5:0] reg_addr,           // Operation register number.
	input  wire       reg_wr,             // Register write strobe.
	input  wire       reg_rd,             // Register read strobe.
	input  wire [7:0] reg_wdata,          // Register write data.
	output reg  [7:0] reg_rdata_r,        // Read data, one cycle after reg_rd.
	input  wire       core_control_wr,            // Core control write strobe.
	input  wire       core_control_rd,            // Core control read strobe.
	output reg  [7:0] core_control_r,             // Core control register contents.
	input  wire [1:0] op_mode,            // Operation mode code.
	input  wire       dual_clock_ctrl,    // Low selects the slow clock.
	output reg        usb_core_run_r,     // High while the USB core may run.
	input  wire       bus_active,         // Bus traffic level from the core.
	input  wire       setup_done,         // Pulse: Setup transaction accepted.
	input  wire       core_ep0_access,    // Level: core uses the EP0 FIFO.
	input  wire       ep0_rx_done,        // Pulse: core wrote EP0 data.
	input  wire       ep2_rx_done,        // Pulse: host data landed at EP2.
	input  wire [2:0] tx_done,            // Pulses: core sent EP0..EP2 data.
	input  wire       vendor_cmd,         // Pulse: vendor command at EP0.
	input  wire       bus_reset,          // Pulse: host bus reset.
	input  wire       tick_overflow,      // Pulse: tick counter overflow.
	input  wire [1:0] pattern_hit,        // Pulses: pattern detectors one, two.
	input  wire [3:0] port7_pins,         // Port seven pins seven to four.
	input  wire [3:0] port7_dir_in,       // High where those pins are inputs.
	input  wire       port7_read,         // Pulse: firmware read port seven.
	input  wire       int_taken,          // Pulse: an interrupt is taken.
	input  wire [7:0] acc_in,             // Live accumulator value.
	output reg  [7:0] acc_saved_r,        // Accumulator saved at interrupt.
	output reg  [7:0] status_r,           // Status flags for the core.
	output reg  [7:0] int_flags_r,        // Interrupt status flags.
	output reg        ep0_write_ok_r,     // Core may write the EP0 FIFO.
	output reg        ep2_accept_r,       // Core may accept EP2 host data.
	input  wire [4:0] core_fifo_addr,     // Core FIFO address.
	input  wire       core_fifo_we,       // Core FIFO write strobe.
	input  wire [7:0] core_fifo_wdata,    // Core FIFO write data.
	output reg  [7:0] core_fifo_rdata_r,  // Core FIFO read data, registered.
	output reg  [7:0] ep0_byte_index_r,   // Copy of the EP0 byte index.
	output reg  [7:0] eeprom_command_r,   // EEPROM command register.
	output reg  [7:0] pattern_ctrl_r,     // Pattern detect control register.
	output reg  [4:0] fifo_ptr_r          // FIFO location pointer.
);

	////////////////////////////////////////////////////////////////////////
	// Declarations.

	reg  [7:0] fifo_mem [0:`FIFO_DEPTH-1];
	reg  [7:0] status_nxt;
	reg  [7:0] int_flags_nxt;
	reg  [7:0] rdata_nxt;
	reg        suspend_d_r;
	wire       host_suspend;
	wire       port_change;
	wire       wr_status;
	wire       wr_flags;
	wire       wr_data;
	wire       suspend_rise;
	wire       suspend_fall;
	wire [7:0] hw_set;
	integer    i;

	// Firmware write strobe for a given register number.
	function fw_write;
		input [5:0] addr;
		input [5:0] ofs;
		input       wr;
		begin
			fw_write = wr & (addr == ofs);
		end
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Helper blocks.

	// Bus idle timer for the host suspend indication.
	bus_idle_timer #(
		.IDLE_CYCLES (SUSPEND_CYCLES)
	) u_idle (
		.clk         (clk),
		.arst_n      (arst_n),
		.bus_active  (bus_active),
		.suspended_r (host_suspend)
	);

	// Port seven change detector.
	port_change_detect u_pchg (
		.clk       (clk),
		.arst_n    (arst_n),
		.pins      (port7_pins),
		.dir_in    (port7_dir_in),
		.port_read (port7_read),
		.op_mode   (op_mode),
		.change_r  (port_change)
	);

	////////////////////////////////////////////////////////////////////////
	// Strobes and events.

	// Decode firmware writes to the registers with side effects.
	assign wr_status = fw_write(reg_addr, `OFS_USB_APP_STATUS, reg_wr);
	assign wr_flags  = fw_write(reg_addr, `OFS_INTERRUPT_FLAGS, reg_wr);
	assign wr_data   = fw_write(reg_addr, `OFS_FIFO_DATA_WINDOW, reg_wr);

	// Edges of the suspend indication.
	assign suspend_rise = host_suspend & ~suspend_d_r;
	assign suspend_fall = ~host_suspend & suspend_d_r;

	// Hardware set events for the interrupt flags, in bit order.
	assign hw_set = {
		suspend_fall & ~dual_clock_ctrl,
		pattern_hit[1],
		pattern_hit[0],
		port_change,
		bus_reset & usb_core_run_r,
		suspend_rise,
		vendor_cmd & usb_core_run_r,
		tick_overflow
	};

	////////////////////////////////////////////////////////////////////////
	// Status flags.

	// Next value of the status register; hardware and firmware share bits.
	always @* begin
		status_nxt = status_r;
		if (wr_status) begin
			status_nxt[`BIT_STALL]       = reg_wdata[`BIT_STALL];
			status_nxt[`BIT_EP0_RX_FULL] = reg_wdata[`BIT_EP0_RX_FULL];
			if (!reg_wdata[`BIT_EP2_RX_FULL]) begin
				status_nxt[`BIT_EP2_RX_FULL] = 1'b0;
			end
		end
		// Completed Setup clears stall unless firmware sets it now.
		if (setup_done && !(wr_status && reg_wdata[`BIT_STALL])) begin
			status_nxt[`BIT_STALL] = 1'b0;
		end
		// Transmit requests: core clears, firmware set wins.
		for (i = 0; i < 3; i = i + 1) begin
			if (tx_done[i]) begin
				status_nxt[`BIT_EP0_TX_REQ + i] = 1'b0;
			end
			if (wr_status && reg_wdata[`BIT_EP0_TX_REQ + i]) begin
				status_nxt[`BIT_EP0_TX_REQ + i] = 1'b1;
			end
		end
		// Receive flags are set by the core only while clear, so a firmware clear wins.
		if (ep2_rx_done && !status_r[`BIT_EP2_RX_FULL]) begin
			status_nxt[`BIT_EP2_RX_FULL] = 1'b1;
		end
		if (ep0_rx_done && !status_r[`BIT_EP0_RX_FULL]) begin
			status_nxt[`BIT_EP0_RX_FULL] = 1'b1;
		end
		status_nxt[`BIT_EP0_CORE_ACCESS] = core_ep0_access;
		status_nxt[`BIT_HOST_SUSPEND]    = host_suspend;
	end

	// Next value of the interrupt flags: zero clears, one keeps, set wins.
	always @* begin
		int_flags_nxt = int_flags_r;
		if (wr_flags) begin
			int_flags_nxt = int_flags_r & reg_wdata;
		end
		int_flags_nxt = int_flags_nxt | hw_set;
	end

	// Status, interrupt flags and the handshake outputs to the core.
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			status_r       <= `RST_USB_APP_STATUS;
			int_flags_r    <= `RST_INTERRUPT_FLAGS;
			suspend_d_r    <= 1'b0;
			ep0_write_ok_r <= 1'b1;
			ep2_accept_r   <= 1'b1;
			usb_core_run_r <= 1'b1;
		end else begin
			status_r       <= status_nxt;
			int_flags_r    <= int_flags_nxt;
			suspend_d_r    <= host_suspend;
			ep0_write_ok_r <= ~status_nxt[`BIT_EP0_RX_FULL];
			ep2_accept_r   <= ~status_nxt[`BIT_EP2_RX_FULL];
			usb_core_run_r <= dual_clock_ctrl;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Application FIFO.

	// FIFO storage; a firmware write through the window wins a collision.
	always @(posedge clk) begin
		if (core_fifo_we && !(wr_data && core_fifo_addr == fifo_ptr_r)) begin
			fifo_mem[core_fifo_addr] <= core_fifo_wdata;
		end
		if (wr_data) begin
			fifo_mem[fifo_ptr_r] <= reg_wdata;
		end
	end

	// Registered FIFO views for the core.
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			core_fifo_rdata_r <= 8'h00;
			ep0_byte_index_r  <= 8'h00;
		end else begin
			core_fifo_rdata_r <= fifo_mem[core_fifo_addr];
			ep0_byte_index_r  <= fifo_mem[`FIFO_EP0_BYTE_INDEX];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Plain storage registers.

	// Pointer, EEPROM command, pattern control and core control.
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			fifo_ptr_r       <= `FIFO_EP0_BASE;
			eeprom_command_r <= `RST_EEPROM_COMMAND;
			pattern_ctrl_r   <= `RST_PATTERN_DETECT_CTRL;
			core_control_r           <= `RST_CORE_CONTROL;
		end else begin
			if (fw_write(reg_addr, `OFS_FIFO_POINTER, reg_wr)) begin
				fifo_ptr_r <= reg_wdata[`FIFO_PTR_W-1:0];
			end
			if (fw_write(reg_addr, `OFS_EEPROM_COMMAND, reg_wr)) begin
				eeprom_command_r <= reg_wdata;
			end
			if (fw_write(reg_addr, `OFS_PATTERN_DETECT_CTRL, reg_wr)) begin
				pattern_ctrl_r <= reg_wdata;
			end
			// The interrupt enable bit is not changed by a control write.
			if (core_control_wr) begin
				core_control_r <= (reg_wdata & ~(8'h01 << `BIT_INT_ENABLE)) |
				          (core_control_r & (8'h01 << `BIT_INT_ENABLE));
			end
		end
	end

	// Accumulator save on interrupt entry.
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			acc_saved_r <= 8'h00;
		end else if (int_taken) begin
			acc_saved_r <= acc_in;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Read path.

	// Read data multiplexer; unmapped numbers read as zero.
	always @* begin
		rdata_nxt = reg_rdata_r;
		if (core_control_rd) begin
			rdata_nxt = core_control_r;
		end else if (reg_rd) begin
			case (reg_addr)
				`OFS_EEPROM_COMMAND:      rdata_nxt = eeprom_command_r;
				`OFS_PATTERN_DETECT_CTRL: rdata_nxt = pattern_ctrl_r;
				`OFS_USB_APP_STATUS:      rdata_nxt = status_r;
				`OFS_FIFO_POINTER:        rdata_nxt = {3'h0, fifo_ptr_r};
				`OFS_FIFO_DATA_WINDOW:    rdata_nxt = fifo_mem[fifo_ptr_r];
				`OFS_INTERRUPT_FLAGS:     rdata_nxt = int_flags_r;
				default:                  rdata_nxt = 8'h00;
			endcase
		end
	end

	// Read data register.
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			reg_rdata_r <= 8'h00;
		end else begin
			reg_rdata_r <= rdata_nxt;
		end
	end

endmodule

/* core/usb_app_map.vh */
// Constants for the application FIFO and status register bank.
// Assumes a core clock of 125 MHz and register numbers in a six-bit space.
`ifndef USB_APP_MAP_VH
`define USB_APP_MAP_VH

// Register numbers in the operation register space.
`define OFS_EEPROM_COMMAND       6'h0a
`define OFS_PATTERN_DETECT_CTRL  6'h0b
`define OFS_USB_APP_STATUS       6'h0c
`define OFS_FIFO_POINTER         6'h0d
`define OFS_FIFO_DATA_WINDOW     6'h0e
`define OFS_INTERRUPT_FLAGS      6'h0f

// Reset values.
`define RST_EEPROM_COMMAND       8'hff
`define RST_PATTERN_DETECT_CTRL  8'h00
`define RST_USB_APP_STATUS       8'h00
`define RST_FIFO_POINTER         8'h00
`define RST_FIFO_DATA_WINDOW     8'h00
`define RST_INTERRUPT_FLAGS      8'h00
`define RST_CORE_CONTROL         8'h3f

// Status register bit positions.
`define BIT_STALL                0
`define BIT_EP0_CORE_ACCESS      1
`define BIT_HOST_SUSPEND         2
`define BIT_EP2_RX_FULL          3
`define BIT_EP0_TX_REQ           4
`define BIT_EP2_TX_REQ           6
`define BIT_EP0_RX_FULL          7

// Interrupt flag bit positions.
`define BIT_TICK_OVF_IF          0
`define BIT_EP0_IF               1
`define BIT_SUSPEND_IF           2
`define BIT_BUS_RESET_IF         3
`define BIT_PORT_CHANGE_IF       4
`define BIT_PATTERN_ONE_IF       5
`define BIT_PATTERN_TWO_IF       6
`define BIT_HOST_RESUME_IF       7

// Core control register bit that software cannot write.
`define BIT_INT_ENABLE           6

// Application FIFO geometry.
`define FIFO_PTR_W               5
`define FIFO_DEPTH               32
`define FIFO_EP0_BASE            5'h00
`define FIFO_EP0_BYTE_INDEX      5'h10

// Operation mode codes.
`define MODE_DETECT              2'h0
`define MODE_USB                 2'h1
`define MODE_SERIAL              2'h2
`define MODE_USB_TEST            2'h3

// Bus idle time before suspend is reported.
`define CLK_MHZ                  125
`define SUSPEND_IDLE_US          3000
`define SUSPEND_CYCLES           19'd375000 // 3000 us at 125 MHz.
`define SUSPEND_CNT_W            19

`endif

/* tb/core_side_model.sv */
// Behavioural model of the USB device core facing the register bank.
// Assumes the bench pulses send_ep0 and send_ep2 for one cycle each.
`timescale 1ns/100ps
`include "usb_app_map.vh"

module core_side_model (
	input  wire       clk,             // Clock.
	input  wire       arst_n,          // Reset.
	input  wire       slow,            // Long delay.
	input  wire       send_ep0,        // EP0 data.
	input  wire       send_ep2,        // EP2 data.
	input  wire [7:0] status_r,        // Status.
	input  wire       ep0_write_ok_r,  // EP0 free.
	input  wire       ep2_accept_r,    // EP2 free.
	output reg  [2:0] tx_done,         // Sent.
	output reg        ep0_rx_done,     // EP0 written.
	output reg        ep2_rx_done,     // EP2 landed.
	output reg        core_ep0_access, // Busy.
	output reg        core_fifo_we,    // Write.
	output wire [4:0] core_fifo_addr,  // Address.
	output wire [7:0] core_fifo_wdata  // Data.
);
	reg [2:0] wait_r;
	reg [1:0] seq_r;

	// Data reads 5a only during a write and a5 otherwise.
	assign core_fifo_addr  = `FIFO_EP0_BASE;
	assign core_fifo_wdata = core_fifo_we ? 8'h5a : 8'ha5;

	// Serves requests, honouring the lock flags.
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			tx_done         <= 3'h0;
			ep0_rx_done     <= 1'b0;
			ep2_rx_done     <= 1'b0;
			core_ep0_access <= 1'b0;
			core_fifo_we    <= 1'b0;
			wait_r          <= 3'h0;
			seq_r           <= 2'h0;
		end else begin
			tx_done      <= 3'h0;
			ep0_rx_done  <= 1'b0;
			ep2_rx_done  <= 1'b0;
			core_fifo_we <= 1'b0;
			if (status_r[6:4] != 3'h0 && tx_done == 3'h0) begin
				if (wait_r == (slow ? 3'h6 : 3'h1)) begin
					tx_done <= status_r[6:4];
					wait_r  <= 3'h0;
				end else begin
					wait_r <= wait_r + 3'h1;
				end
			end
			if (seq_r == 2'h0 && send_ep0 && ep0_write_ok_r) begin
				core_ep0_access <= 1'b1;
				seq_r           <= 2'h1;
			end else if (seq_r == 2'h1) begin
				core_fifo_we <= 1'b1;
				seq_r        <= 2'h2;
			end else if (seq_r == 2'h2) begin
				core_ep0_access <= 1'b0;
				ep0_rx_done     <= 1'b1;
				seq_r           <= 2'h0;
			end
			ep2_rx_done <= send_ep2 && ep2_accept_r;
		end
	end
endmodule

/* tb/tb.sv */
// Bench for the status register bank and a core model.
// Assumes the header is on the include path.
`timescale 1ns/100ps
`include "usb_app_map.vh"

module tb;
	reg         clk;
	reg         arst_n;
	reg  [5:0]  reg_addr;
	reg         reg_wr;
	reg         reg_rd;
	reg  [7:0]  reg_wdata;
	reg  [1:0]  op_mode;
	reg         dual_clock_ctrl;
	reg         bus_active;
	reg  [11:0] ev;
	reg  [3:0]  port7_pins;
	reg         slow;
	integer     tests_run;
	integer     fail_count;
	integer     i;
	wire [7:0]  reg_rdata_r, core_control_r, acc_saved_r, status_r, int_flags_r, ep0_byte_index_r, core_fifo_wdata;
	wire [4:0]  fifo_ptr_r, core_fifo_addr;
	wire [2:0]  tx_done;
	wire        usb_core_run_r, ep0_write_ok_r, ep2_accept_r, core_ep0_access, ep0_rx_done, ep2_rx_done;
	wire        core_fifo_we;

	usb_app_fifo_status_regs #(.SUSPEND_CYCLES(19'd20)) dut (.clk, .arst_n, .reg_addr, .reg_wr, .reg_rd,
		.reg_wdata, .reg_rdata_r, .core_control_wr(ev[8]), .core_control_rd(1'b0), .core_control_r, .op_mode, .dual_clock_ctrl,
		.usb_core_run_r, .bus_active, .setup_done(ev[0]), .core_ep0_access, .ep0_rx_done, .ep2_rx_done,
		.tx_done, .vendor_cmd(ev[1]), .bus_reset(ev[2]), .tick_overflow(ev[3]), .pattern_hit(ev[5:4]),
		.port7_pins, .port7_dir_in(4'hf), .port7_read(ev[7]), .int_taken(ev[6]), .acc_in(reg_wdata),
		.acc_saved_r, .status_r, .int_flags_r, .ep0_write_ok_r, .ep2_accept_r, .core_fifo_addr,
		.core_fifo_we, .core_fifo_wdata, .core_fifo_rdata_r(), .ep0_byte_index_r, .eeprom_command_r(),
		.pattern_ctrl_r(), .fifo_ptr_r);

	core_side_model model (.clk, .arst_n, .slow, .send_ep0(ev[10]), .send_ep2(ev[11]), .status_r,
		.ep0_write_ok_r, .ep2_accept_r, .tx_done, .ep0_rx_done, .ep2_rx_done, .core_ep0_access,
		.core_fifo_we, .core_fifo_addr, .core_fifo_wdata);

	////////////////////////////////////////////////////////////////////////
	// Clock and bus tasks.
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	task check(input [7:0] seen, input [7:0] exp);
		begin
			tests_run = tests_run + 1;
			if (seen !== exp) begin
				fail_count = fail_count + 1;
				$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
			end
		end
	endtask

	task wr(input [5:0] a, input [7:0] d);
		begin
			@(posedge clk);
			reg_addr  <= a;
			reg_wdata <= d;
			reg_wr    <= 1'b1;
			@(posedge clk);
			reg_wr <= 1'b0;
			#1;
		end
	endtask

	task rd_chk(input [5:0] a, input [7:0] exp);
		begin
			@(posedge clk);
			reg_addr <= a;
			reg_rd   <= 1'b1;
			@(posedge clk);
			reg_rd <= 1'b0;
			#1;
			check(reg_rdata_r, exp);
		end
	endtask

	task pulse(input [11:0] m, input [7:0] d);
		begin
			@(posedge clk);
			ev        <= m;
			reg_wdata <= d;
			@(posedge clk);
			ev <= 12'h000;
			#1;
		end
	endtask

	task settle(input integer n);
		begin
			repeat (n) @(posedge clk);
			#1;
		end
	endtask

	task print_verdict;
		begin
			$display("comparisons %0d, mismatches %0d", tests_run, fail_count);
			if (fail_count == 0 && tests_run > 0) begin
				$display("bench passed");
			end else begin
				$display("bench failed");
			end
			$finish;
		end
	endtask

	// A hang counts as a mismatch.
	initial begin
		repeat (4000) @(posedge clk);
		fail_count = fail_count + 1;
		print_verdict;
	end

	////////////////////////////////////////////////////////////////////////
	// Main sequence.
	initial begin
		arst_n = 1'b0; reg_addr = 6'h00; reg_wr = 1'b0; reg_rd = 1'b0; reg_wdata = 8'h00;
		op_mode = `MODE_USB; dual_clock_ctrl = 1'b1; bus_active = 1'b1; ev = 12'h000;
		port7_pins = 4'h0; slow = 1'b0; tests_run = 0; fail_count = 0;
		repeat (12) @(posedge clk);
		arst_n <= 1'b1;
		rd_chk(`OFS_EEPROM_COMMAND, `RST_EEPROM_COMMAND);
		rd_chk(`OFS_PATTERN_DETECT_CTRL, `RST_PATTERN_DETECT_CTRL);
		rd_chk(`OFS_USB_APP_STATUS, `RST_USB_APP_STATUS);
		rd_chk(`OFS_FIFO_POINTER, `RST_FIFO_POINTER);
		rd_chk(`OFS_INTERRUPT_FLAGS, `RST_INTERRUPT_FLAGS);
		rd_chk(6'h20, 8'h00);
		check(core_control_r, `RST_CORE_CONTROL);
		pulse(12'h100, 8'hff);
		check(core_control_r, 8'hbf);
		wr(`OFS_FIFO_POINTER, 8'hff);
		rd_chk(`OFS_FIFO_POINTER, 8'h1f);
		wr(`OFS_FIFO_POINTER, {3'h0, `FIFO_EP0_BYTE_INDEX});
		wr(`OFS_FIFO_DATA_WINDOW, 8'h03);
		rd_chk(`OFS_FIFO_DATA_WINDOW, 8'h03);
		check(ep0_byte_index_r, 8'h03);
		// Firmware locks and loads the EP0 FIFO.
		wr(`OFS_FIFO_POINTER, {3'h0, `FIFO_EP0_BASE});
		wr(`OFS_USB_APP_STATUS, 8'h80);
		wr(`OFS_FIFO_DATA_WINDOW, 8'h11);
		check(ep0_write_ok_r, 1'b0);
		pulse(12'h400, 8'h00);
		settle(4);
		rd_chk(`OFS_FIFO_DATA_WINDOW, 8'h11);
		wr(`OFS_USB_APP_STATUS, 8'h00);
		pulse(12'h400, 8'h00);
		settle(4);
		check(status_r[7], 1'b1);
		rd_chk(`OFS_FIFO_DATA_WINDOW, 8'h5a);
		wr(`OFS_USB_APP_STATUS, 8'h00);
		// EP2 data locks out more until cleared.
		pulse(12'h800, 8'h00);
		settle(1);
		check({status_r[3], ep2_accept_r}, 2'h2);
		wr(`OFS_USB_APP_STATUS, 8'h08);
		check(status_r[3], 1'b1);
		wr(`OFS_USB_APP_STATUS, 8'h00);
		check({status_r[3], ep2_accept_r}, 2'h1);
		// Zero writes ignored; the core clears requests.
		@(posedge clk);
		slow <= 1'b1;
		check(status_r[4], 1'b0);
		wr(`OFS_USB_APP_STATUS, 8'h10);
		wr(`OFS_USB_APP_STATUS, 8'h00);
		check(status_r[4], 1'b1);
		for (i = 0; i < 20 && status_r[6:4] !== 3'h0; i = i + 1) settle(1);
		check(status_r[6:4], 3'h0);
		@(posedge clk);
		slow <= 1'b0;
		wr(`OFS_USB_APP_STATUS, 8'h70);
		for (i = 0; i < 20 && status_r[6:4] !== 3'h0; i = i + 1) settle(1);
		check(status_r[6:4], 3'h0);
		wr(`OFS_USB_APP_STATUS, 8'h01);
		check(status_r[0], 1'b1);
		pulse(12'h001, 8'h00);
		check(status_r[0], 1'b0);
		// Flags: events set, zero clears, set wins.
		wr(`OFS_INTERRUPT_FLAGS, 8'h00);
		pulse(12'h03e, 8'h00);
		rd_chk(`OFS_INTERRUPT_FLAGS, 8'h6b);
		wr(`OFS_INTERRUPT_FLAGS, 8'hff);
		rd_chk(`OFS_INTERRUPT_FLAGS, 8'h6b);
		@(posedge clk);
		reg_addr  <= `OFS_INTERRUPT_FLAGS;
		reg_wdata <= 8'h00;
		reg_wr    <= 1'b1;
		ev        <= 12'h008;
		@(posedge clk);
		reg_wr <= 1'b0;
		ev     <= 12'h000;
		#1;
		check(int_flags_r, 8'h01);
		pulse(12'h040, 8'hc3);
		check(acc_saved_r, 8'hc3);
		// Port change in serial and USB modes.
		wr(`OFS_INTERRUPT_FLAGS, 8'h00);
		op_mode <= `MODE_SERIAL;
		pulse(12'h080, 8'h00);
		port7_pins <= 4'h1;
		settle(3);
		check(int_flags_r[4], 1'b1);
		wr(`OFS_INTERRUPT_FLAGS, 8'h00);
		op_mode <= `MODE_USB;
		pulse(12'h080, 8'h00);
		port7_pins <= 4'h3;
		settle(3);
		check(int_flags_r[4], 1'b0);
		port7_pins <= 4'hb;
		settle(3);
		check(int_flags_r[4], 1'b1);
		// Idle gives suspend; activity gives resume.
		wr(`OFS_INTERRUPT_FLAGS, 8'h00);
		bus_active <= 1'b0;
		settle(30);
		check({status_r[2], int_flags_r[2]}, 2'h3);
		dual_clock_ctrl <= 1'b0;
		@(posedge clk);
		bus_active <= 1'b1;
		settle(4);
		check({status_r[2], int_flags_r[7], usb_core_run_r}, 3'h2);
		pulse(12'h002, 8'h00);
		check(int_flags_r[1], 1'b0);
		dual_clock_ctrl <= 1'b1;
		settle(2);
		print_verdict;
	end
endmodule

/* tb/usb_app_regs_asserts.sv */
// Port checks for the status register bank.
// Assumes one clock domain.
`timescale 1ns/100ps
`include "usb_app_map.vh"

module usb_app_regs_asserts (
	input wire       clk,             // Clock.
	input wire       arst_n,          // Reset.
	input wire [5:0] reg_addr,        // Address.
	input wire       reg_wr,          // Write.
	input wire       reg_rd,          // Read.
	input wire [7:0] reg_wdata,       // Data in.
	input wire [7:0] reg_rdata_r,     // Data out.
	input wire       core_control_rd,         // Control read.
	input wire       bus_active,      // Traffic.
	input wire       setup_done,      // Setup.
	input wire       core_ep0_access, // Busy.
	input wire       tick_overflow,   // Overflow.
	input wire [2:0] tx_done,         // Sent.
	input wire       int_taken,       // Interrupt.
	input wire [7:0] acc_in,          // Live.
	input wire [7:0] acc_saved_r,     // Saved.
	input wire [7:0] status_r,        // Status.
	input wire [7:0] int_flags_r,     // Flags.
	input wire       ep2_accept_r,    // Accept.
	input wire [4:0] fifo_ptr_r,      // Pointer.
	input wire       dual_clock_ctrl, // Clock mode.
	input wire       usb_core_run_r   // Run.
);
	wire st_wr = reg_wr && reg_addr == `OFS_USB_APP_STATUS;
	wire fl_wr = reg_wr && reg_addr == `OFS_INTERRUPT_FLAGS;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!arst_n);

	////////////////////////////////////////////////////////////////////////
	// Output checks.
	chk_busy_mirror: assert property (status_r[1] == $past(core_ep0_access))
		else $error("busy flag wrong");
	chk_ptr_upper: assert property (reg_rd && !core_control_rd && reg_addr == `OFS_FIFO_POINTER |=>
		reg_rdata_r == {3'h0, $past(fifo_ptr_r)}) else $error("pointer read wrong");
	chk_stall_clear: assert property (setup_done && !st_wr |=> !status_r[0])
		else $error("stall kept");
	chk_ep2_hold: assert property (status_r[3] && !st_wr |=> status_r[3])
		else $error("ep2 flag lost");
	chk_ep2_accept: assert property (ep2_accept_r == !status_r[3])
		else $error("ep2 accept wrong");
	chk_tx_sw_set: assert property (!$past(status_r[4]) && status_r[4] |->
		$past(st_wr && reg_wdata[4])) else $error("tx set by hardware");
	chk_tx_hw_clear: assert property (tx_done[0] && status_r[4] && !(st_wr && reg_wdata[4]) |=>
		!status_r[4]) else $error("tx not cleared");
	chk_tick_flag: assert property (tick_overflow |=> int_flags_r[0])
		else $error("tick flag unset");
	chk_flag_clear: assert property (fl_wr && !reg_wdata[0] && !tick_overflow |=> !int_flags_r[0])
		else $error("flag not cleared");
	chk_flag_keep: assert property (fl_wr && reg_wdata[0] && int_flags_r[0] |=> int_flags_r[0])
		else $error("flag lost");
	chk_acc_save: assert property (int_taken |=> acc_saved_r == $past(acc_in))
		else $error("acc not saved");
	chk_run_follow: assert property (usb_core_run_r == $past(dual_clock_ctrl))
		else $error("run flag wrong");
	chk_suspend_drop: assert property ($rose(bus_active) |-> ##[1:3] !status_r[2])
		else $error("suspend kept");
endmodule

bind usb_app_fifo_status_regs usb_app_regs_asserts u_chk (.clk, .arst_n, .reg_addr, .reg_wr, .reg_rd,
	.reg_wdata, .reg_rdata_r, .core_control_rd, .bus_active, .setup_done, .core_ep0_access, .tick_overflow,
	.tx_done, .int_taken, .acc_in, .acc_saved_r, .status_r, .int_flags_r, .ep2_accept_r, .fifo_ptr_r,
	.dual_clock_ctrl, .usb_core_run_r);
